// *** rtl/shunt_monitor_result_scaling.sv ***
`timescale 1ns/1ps
module shunt_monitor_result_scaling
	import shunt_monitor_pkg::*;
#(
	parameter int unsigned CONV_CYCLES_P [8] = CONV_CYCLES
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Register access port
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic i_reg_rd,
	output logic [15:0] o_reg_rdata,
	output logic o_reg_rvalid,
	// ADC front end
	input wire logic [15:0] i_shunt_code,
	input wire logic [15:0] i_bus_code,
	output logic o_shunt_range_select,
	output logic o_conv_strobe,
	// Status
	output logic o_conversion_complete_flag
);
	logic [15:0] config_ff;
	logic [14:0] cal_ff;
	logic [15:0] shunt_res_ff;
	logic [15:0] bus_res_ff;
	logic [15:0] current_res_ff;
	logic [15:0] power_res_ff;
	logic [15:0] shunt_avg_ff;
	logic [15:0] bus_avg_ff;
	logic [15:0] cur_calc_ff;
	logic [15:0] pow_calc_ff;
	logic [TIMER_W-1:0] timer_ff;
	logic done_flag_ff;
	math_state_t state_ff;
	math_state_t nxt_state;

	logic cfg_wr;
	logic cal_wr;
	logic status_rd;
	logic take_sample;
	logic sample_ok;
	logic [TIMER_W-1:0] conv_last;
	logic [2:0] ct_sel;
	logic [2:0] avg_sel;
	logic [3:0] avg_shift;
	logic shunt_avg_done;
	logic [15:0] shunt_avg;
	logic [15:0] bus_avg;
	logic signed [31:0] cur_prod;
	logic signed [31:0] cur_scaled;
	logic [15:0] cur_sat;
	logic cal_zero;
	logic [16:0] cur_mag;
	logic [32:0] pow_prod;
	logic [32:0] pow_scaled;
	logic [15:0] pow_sat;
	logic [15:0] rd_mux;
	logic [15:0] status_word;

	// Decode of register strobes and config fields
	assign cfg_wr = i_reg_wr && (i_reg_addr == ADDR_CONFIG);
	assign cal_wr = i_reg_wr && (i_reg_addr == ADDR_CAL);
	assign status_rd = i_reg_rd && (i_reg_addr == ADDR_STATUS);
	assign ct_sel = config_ff[CFG_CT_LSB+:3];
	assign avg_sel = config_ff[CFG_AVG_LSB+:3];
	assign avg_shift = AVG_SHIFT[avg_sel];

	// Configuration register, all bits stored and read back
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			config_ff <= CONFIG_RESET;
		end else if (cfg_wr) begin
			config_ff <= i_reg_wdata;
		end
	end

	// Calibration register, top bit dropped so it reads zero
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			cal_ff <= CAL_RESET;
		end else if (cal_wr) begin
			cal_ff <= i_reg_wdata[14:0];
		end
	end

	// Range select to the front end selects 81.92 mV or 20.48 mV scale
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_shunt_range_select <= 1'b0;
		end else begin
			o_shunt_range_select <= config_ff[CFG_RANGE_BIT];
		end
	end

	// Conversion timer, restarted by a config write
	assign conv_last = TIMER_W'(CONV_CYCLES_P[ct_sel] - 1);
	assign take_sample = (timer_ff == conv_last);
	assign sample_ok = take_sample && !cfg_wr;
	always_ff @(posedge i_clk) begin
		if (!i_nrst || cfg_wr) begin
			timer_ff <= '0;
		end else if (take_sample) begin
			timer_ff <= '0;
		end else begin
			timer_ff <= timer_ff + TIMER_W'(1);
		end
	end

	// Strobe marking each sampled conversion
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_conv_strobe <= 1'b0;
		end else begin
			o_conv_strobe <= sample_ok;
		end
	end

	// Averaging of shunt (signed) and bus (unsigned) samples
	sample_averager u_shunt_avg (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_clear(cfg_wr),
		.i_signed(1'b1),
		.i_shift(avg_shift),
		.i_add(sample_ok),
		.i_sample(i_shunt_code),
		.o_avg(shunt_avg),
		.o_done(shunt_avg_done)
	);
	sample_averager u_bus_avg (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_clear(cfg_wr),
		.i_signed(1'b0),
		.i_shift(avg_shift),
		.i_add(sample_ok),
		.i_sample(i_bus_code),
		.o_avg(bus_avg),
		.o_done()
	);

	// Math sequencer
	always_comb begin
		case (state_ff)
			ST_IDLE: nxt_state = shunt_avg_done ? ST_CUR : ST_IDLE;
			ST_CUR: nxt_state = ST_POW;
			ST_POW: nxt_state = ST_PUB;
			ST_PUB: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end
	always_ff @(posedge i_clk) begin
		if (!i_nrst || cfg_wr) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Hold averaged shunt sample for the math
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			shunt_avg_ff <= RESULT_RESET;
		end else if (state_ff == ST_IDLE && shunt_avg_done) begin
			shunt_avg_ff <= shunt_avg;
		end
	end

	// Hold averaged bus sample, taken with the shunt one
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			bus_avg_ff <= RESULT_RESET;
		end else if (state_ff == ST_IDLE && shunt_avg_done) begin
			bus_avg_ff <= bus_avg;
		end
	end

	// Zero calibration disables the current math
	assign cal_zero = (cal_ff == 15'h0000);

	// Current: signed shunt times calibration, saturated to 16 bits
	always_comb begin
		cur_prod = $signed(shunt_avg_ff) * $signed({1'b0, cal_ff});
		cur_scaled = cur_prod >>> CUR_SHIFT;
		if (cal_zero) begin
			cur_sat = 16'h0000;
		end else if (cur_scaled > CUR_MAX) begin
			cur_sat = 16'h7fff;
		end else if (cur_scaled < CUR_MIN) begin
			cur_sat = 16'h8000;
		end else begin
			cur_sat = cur_scaled[15:0];
		end
	end

	// Power: current magnitude times bus voltage, saturated to 16 bits
	always_comb begin
		cur_mag = cur_calc_ff[15] ? 17'(17'h00000 - {1'b1, cur_calc_ff}) : {1'b0, cur_calc_ff};
		pow_prod = 33'(cur_mag * bus_avg_ff);
		pow_scaled = pow_prod >> POWER_SHIFT;
		pow_sat = (pow_scaled > 33'h00000ffff) ? 16'hffff : pow_scaled[15:0];
	end

	// Current pipeline register, loaded in the current step
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			cur_calc_ff <= RESULT_RESET;
		end else if (state_ff == ST_CUR) begin
			cur_calc_ff <= cur_sat;
		end
	end

	// Power pipeline register, uses the current held one step earlier
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			pow_calc_ff <= RESULT_RESET;
		end else if (state_ff == ST_POW) begin
			pow_calc_ff <= pow_sat;
		end
	end

	// Publish measured results in the publish step
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			shunt_res_ff <= RESULT_RESET;
			bus_res_ff <= RESULT_RESET;
		end else if (state_ff == ST_PUB) begin
			shunt_res_ff <= shunt_avg_ff;
			bus_res_ff <= bus_avg_ff;
		end
	end

	// Publish derived results in that same step, never split
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			current_res_ff <= RESULT_RESET;
			power_res_ff <= RESULT_RESET;
		end else if (state_ff == ST_PUB) begin
			current_res_ff <= cur_calc_ff;
			power_res_ff <= pow_calc_ff;
		end
	end

	// Completion flag: set in publish, cleared by config write or status read, set wins
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			done_flag_ff <= 1'b0;
		end else if (state_ff == ST_PUB) begin
			done_flag_ff <= 1'b1;
		end else if (cfg_wr || status_rd) begin
			done_flag_ff <= 1'b0;
		end
	end
	assign o_conversion_complete_flag = done_flag_ff;

	// Status word with only the completion flag
	assign status_word = 16'(done_flag_ff) << STAT_DONE_BIT;

	// Read mux, unmapped addresses read zero
	always_comb begin
		case (i_reg_addr)
			ADDR_CONFIG: rd_mux = config_ff;
			ADDR_SHUNT: rd_mux = shunt_res_ff;
			ADDR_BUS: rd_mux = bus_res_ff;
			ADDR_POWER: rd_mux = power_res_ff;
			ADDR_CURRENT: rd_mux = current_res_ff;
			ADDR_CAL: rd_mux = {1'b0, cal_ff};
			ADDR_STATUS: rd_mux = status_word;
			ADDR_MAKER: rd_mux = MAKER_CODE;
			default: rd_mux = 16'h0000;
		endcase
	end

	// Read answer valid, one cycle after the strobe
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_rd;
		end
	end

	// Read data, held until the next read
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_reg_rdata <= 16'h0000;
		end else if (i_reg_rd) begin
			o_reg_rdata <= rd_mux;
		end
	end
endmodule

// *** rtl/shunt_monitor_pkg.sv ***
package shunt_monitor_pkg;

	// Register addresses
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_SHUNT = 8'h01;
	localparam logic [7:0] ADDR_BUS = 8'h02;
	localparam logic [7:0] ADDR_POWER = 8'h03;
	localparam logic [7:0] ADDR_CURRENT = 8'h04;
	localparam logic [7:0] ADDR_CAL = 8'h05;
	localparam logic [7:0] ADDR_STATUS = 8'h06;
	localparam logic [7:0] ADDR_MAKER = 8'h3e;

	// Maker code, value is arbitrary
	localparam logic [15:0] MAKER_CODE = 16'h4142;

	// Reset values
	localparam logic [15:0] CONFIG_RESET = 16'h0000;
	localparam logic [14:0] CAL_RESET = 15'h0000;
	localparam logic [15:0] RESULT_RESET = 16'h0000;

	// Config field positions
	localparam int unsigned CFG_CT_LSB = 3;
	localparam int unsigned CFG_AVG_LSB = 9;
	localparam int unsigned CFG_RANGE_BIT = 12;

	// Status field positions
	localparam int unsigned STAT_DONE_BIT = 3;

	// Scaling
	localparam int unsigned CUR_SHIFT = 11;
	localparam int unsigned POWER_SHIFT = 13;
	localparam logic signed [31:0] CUR_MAX = 32'sd32767;
	localparam logic signed [31:0] CUR_MIN = -32'sd32768;

	// Averaging: log2 of sample count per setting
	localparam logic [3:0] AVG_SHIFT [8] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha};

	// Conversion times in microseconds and derived cycle counts
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned CONV_TIME_US [8] = '{140, 204, 332, 588, 1100, 2116, 4156, 8244};
	localparam int unsigned CONV_CYCLES [8] = '{
		CONV_TIME_US[0] * CLK_MHZ, CONV_TIME_US[1] * CLK_MHZ,
		CONV_TIME_US[2] * CLK_MHZ, CONV_TIME_US[3] * CLK_MHZ,
		CONV_TIME_US[4] * CLK_MHZ, CONV_TIME_US[5] * CLK_MHZ,
		CONV_TIME_US[6] * CLK_MHZ, CONV_TIME_US[7] * CLK_MHZ};
	localparam int unsigned TIMER_W = 22;

	// Math sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CUR = 2'b01,
		ST_POW = 2'b11,
		ST_PUB = 2'b10
	} math_state_t;

endpackage

// *** rtl/sample_averager.sv ***
`timescale 1ns/1ps
module sample_averager
	import shunt_monitor_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Control
	input wire logic i_clear,
	input wire logic i_signed,
	input wire logic [3:0] i_shift,
	// Samples
	input wire logic i_add,
	input wire logic [15:0] i_sample,
	// Result
	output logic [15:0] o_avg,
	output logic o_done
);
	logic signed [27:0] acc_ff;
	logic [10:0] cnt_ff;
	logic signed [27:0] ext;
	logic signed [27:0] sum;
	logic signed [27:0] avg_full;

	// Sign or zero extension, then running sum
	always_comb begin
		ext = i_signed ? 28'(signed'(i_sample)) : {12'h000, i_sample};
		sum = acc_ff + ext;
		avg_full = sum >>> i_shift;
	end

	// Accumulate until the selected count is reached
	always_ff @(posedge i_clk) begin
		if (!i_nrst || i_clear) begin
			acc_ff <= 28'sh0000000;
			cnt_ff <= 11'h000;
			o_avg <= 16'h0000;
			o_done <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_add) begin
				if (cnt_ff + 11'h001 == 11'(11'h001 << i_shift)) begin
					o_avg <= avg_full[15:0];
					o_done <= 1'b1;
					acc_ff <= 28'sh0000000;
					cnt_ff <= 11'h000;
				end else begin
					acc_ff <= sum;
					cnt_ff <= cnt_ff + 11'h001;
				end
			end
		end
	end
endmodule

// *** test/shunt_monitor_properties.sv ***
`timescale 1ns/1ps
module shunt_monitor_properties
	import shunt_monitor_pkg::*;
#(
	parameter int unsigned CONV_CYCLES_P [8] = CONV_CYCLES
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Register port
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic i_reg_rd,
	input wire logic [15:0] o_reg_rdata,
	input wire logic o_reg_rvalid,
	// Front end and status
	input wire logic o_shunt_range_select,
	input wire logic o_conv_strobe,
	input wire logic o_conversion_complete_flag
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	// Read answers and held data
	property p_rvalid; i_reg_rd |=> o_reg_rvalid; endproperty
	a_rvalid: assert property (p_rvalid) else $error("read not answered");
	property p_no_rvalid; !i_reg_rd |=> !o_reg_rvalid; endproperty
	a_no_rvalid: assert property (p_no_rvalid) else $error("stray read answer");
	property p_hold; !$past(i_reg_rd) |-> $stable(o_reg_rdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_maker; i_reg_rd && i_reg_addr == ADDR_MAKER |=> o_reg_rdata == MAKER_CODE; endproperty
	a_maker: assert property (p_maker) else $error("maker code wrong");
	property p_unmapped; i_reg_rd && i_reg_addr == 8'h10 |=> o_reg_rdata == 16'h0000; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_range;
		i_reg_wr && i_reg_addr == ADDR_CONFIG |-> ##2 o_shunt_range_select == $past(i_reg_wdata[CFG_RANGE_BIT], 2);
	endproperty
	a_range: assert property (p_range) else $error("range select wrong");
	property p_strobe; o_conv_strobe |=> !o_conv_strobe [*8]; endproperty
	a_strobe: assert property (p_strobe) else $error("strobe too close");
	property p_flag; $rose(o_conversion_complete_flag) |-> $past(o_conv_strobe, 4); endproperty
	a_flag: assert property (p_flag) else $error("flag before math done");
	property p_status;
		i_reg_rd && i_reg_addr == ADDR_STATUS |=> o_reg_rdata[STAT_DONE_BIT] == $past(o_conversion_complete_flag);
	endproperty
	a_status: assert property (p_status) else $error("status bit wrong");
endmodule
bind shunt_monitor_result_scaling shunt_monitor_properties #(.CONV_CYCLES_P(CONV_CYCLES_P)) chk_u (
	.i_clk(i_clk),
	.i_nrst(i_nrst),
	.i_reg_addr(i_reg_addr),
	.i_reg_wr(i_reg_wr),
	.i_reg_wdata(i_reg_wdata),
	.i_reg_rd(i_reg_rd),
	.o_reg_rdata(o_reg_rdata),
	.o_reg_rvalid(o_reg_rvalid),
	.o_shunt_range_select(o_shunt_range_select),
	.o_conv_strobe(o_conv_strobe),
	.o_conversion_complete_flag(o_conversion_complete_flag)
);

// *** test/shunt_host_model.sv ***
`timescale 1ns/1ps
module shunt_host_model (
	// Clock and read answer
	input wire logic i_clk,
	input wire logic [15:0] i_rdata,
	input wire logic i_rvalid,
	// Request lines
	output logic [7:0] o_addr,
	output logic o_wr,
	output logic [15:0] o_wdata,
	output logic o_rd
);
	// Calibration for a wide range setup, no divide by 4 needed
	localparam logic [15:0] CAL_NOMINAL = 16'h0800;
	// Narrow range setup divides the calibration by four
	localparam logic [15:0] CAL_NARROW = CAL_NOMINAL >> 2;
	// Idle request lines
	initial begin
		o_addr = 8'h00;
		o_wr = 1'b0;
		o_wdata = 16'h0000;
		o_rd = 1'b0;
	end
	// One-cycle write, released lines inverted
	task automatic write(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask
	// One-cycle read, answer taken at the edge where valid stands
	task automatic read(input logic [7:0] a, output logic [15:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		@(posedge i_clk);
		d = i_rvalid ? i_rdata : 16'hxxxx;
	endtask
endmodule

// *** test/shunt_monitor_result_scaling_tb.sv ***
`timescale 1ns/1ps
module shunt_monitor_result_scaling_tb;
	import shunt_monitor_pkg::*;
	logic i_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic [15:0] i_shunt_code = 16'h0000;
	logic [15:0] i_bus_code = 16'h0000;
	logic [7:0] i_reg_addr;
	logic i_reg_wr, i_reg_rd, o_reg_rvalid, o_shunt_range_select, o_conv_strobe, o_conversion_complete_flag;
	logic [15:0] i_reg_wdata, o_reg_rdata;
	int num_errors = 0;
	int total_checks = 0;
	int n_strobe, n_cyc;
	// Short conversion periods for simulation
	localparam int unsigned SIM_CONV [8] = '{20, 30, 40, 50, 60, 70, 80, 90};
	// Clock
	always #2 i_clk = ~i_clk;
	shunt_monitor_result_scaling #(.CONV_CYCLES_P(SIM_CONV)) dut_u (.i_clk(i_clk),
		.i_nrst(i_nrst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
		.i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_shunt_code(i_shunt_code),
		.i_bus_code(i_bus_code), .o_shunt_range_select(o_shunt_range_select), .o_conv_strobe(o_conv_strobe),
		.o_conversion_complete_flag(o_conversion_complete_flag));
	shunt_host_model host_u (.i_clk(i_clk), .i_rdata(o_reg_rdata), .i_rvalid(o_reg_rvalid), .o_addr(i_reg_addr),
		.o_wr(i_reg_wr), .o_wdata(i_reg_wdata), .o_rd(i_reg_rd));
	// Compare and read helpers
	task automatic chk16(string name, logic [15:0] exp, logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic rd_chk(string name, logic [7:0] a, logic [15:0] exp);
		logic [15:0] d;
		host_u.read(a, d);
		chk16(name, exp, d);
	endtask
	// Count strobes and cycles until the completion flag
	task automatic wait_flag();
		n_strobe = 0;
		n_cyc = 0;
		do begin
			@(negedge i_clk);
			n_cyc++;
			if (o_conv_strobe === 1'b1) n_strobe++;
		end while (o_conversion_complete_flag !== 1'b1 && n_cyc < 2000);
		chk16("flag", 16'h0001, {15'h0, o_conversion_complete_flag});
	endtask
	task automatic t_ids();
		rd_chk("maker", ADDR_MAKER, MAKER_CODE);
		host_u.write(ADDR_MAKER, 16'h0000);
		rd_chk("maker_ro", ADDR_MAKER, MAKER_CODE);
		rd_chk("unmapped", 8'h10, 16'h0000);
		rd_chk("cal_rst", ADDR_CAL, 16'h0000);
	endtask
	task automatic t_zero_cal();
		@(posedge i_clk);
		i_shunt_code <= 16'hff9c;
		i_bus_code <= 16'h1000;
		host_u.write(ADDR_CONFIG, 16'h0000);
		wait_flag();
		chk16("strobes1", 16'd1, n_strobe[15:0]);
		chk16("fast_conv", 16'(SIM_CONV[0] + 5), n_cyc[15:0]);
		rd_chk("shunt", ADDR_SHUNT, 16'hff9c);
		rd_chk("bus", ADDR_BUS, 16'h1000);
		rd_chk("cur_zero", ADDR_CURRENT, 16'h0000);
		rd_chk("status", ADDR_STATUS, 16'h0008);
		chk16("flag_clr", 16'h0000, {15'h0, o_conversion_complete_flag});
	endtask
	task automatic t_scale();
		host_u.write(ADDR_CAL, {1'b1, host_u.CAL_NOMINAL[14:0]});
		rd_chk("cal", ADDR_CAL, host_u.CAL_NOMINAL);
		host_u.write(ADDR_CONFIG, 16'h0208);
		wait_flag();
		chk16("strobes4", 16'd4, n_strobe[15:0]);
		chk16("slow_conv", 16'(4 * SIM_CONV[1] + 5), n_cyc[15:0]);
		rd_chk("current", ADDR_CURRENT, 16'hff9c);
		rd_chk("power", ADDR_POWER, 16'h0032);
	endtask
	task automatic t_range();
		host_u.write(ADDR_CONFIG, 16'h1000);
		rd_chk("cfg", ADDR_CONFIG, 16'h1000);
		chk16("narrow", 16'h0001, {15'h0, o_shunt_range_select});
		host_u.write(ADDR_CAL, host_u.CAL_NARROW);
		wait_flag();
		rd_chk("cur_narrow", ADDR_CURRENT, 16'hffe7);
		rd_chk("pow_narrow", ADDR_POWER, 16'h000c);
		host_u.write(ADDR_CONFIG, 16'h0000);
		rd_chk("cfg0", ADDR_CONFIG, 16'h0000);
		chk16("wide", 16'h0000, {15'h0, o_shunt_range_select});
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge i_clk);
		i_nrst <= 1'b1;
		t_ids();
		t_zero_cal();
		t_scale();
		t_range();
		end_of_test();
	end
	// Watchdog
	initial begin
		repeat (20000) @(posedge i_clk);
		num_errors++;
		end_of_test();
	end
endmodule
